// ---- swd_pkg.sv ----
// Purpose: constants and types for the single-wire debug port logic
// Assumes: one 50 MHz clock, serial clock equals clk
// Notes: timing counts are in serial clock cycles
// Function
// - falling edge starts; long low is sync
// - after sync wait for rise, forever
// - short low pulse decodes as one bit
// - 512 cycles without edge soft resets
// - no handshake: read data expires after 512
// - handshake on: read wait has no time-out
// - after handshake pulse, 512 cycle time-out restarts
// - time-out active while transfer partly done
// - after soft reset next edge starts fresh
// - step runs one instruction then returns
// - pending interrupt: step only stacks interrupt
// - stepped stop/wait: low power, commands except halt still work
// - system stop blocks every debug command
// - leaving low power re-enters debug mode
// - no handshake pulse on the return from stepped stop/wait
// - system stop clears handshake enable
// - handshake disabled after reset
// - sync reply: wait 16, drive low 128
package swd_pkg;
  localparam int unsigned SWD_SYNC_MIN = 128;
  localparam int unsigned SWD_TIMEOUT = 512;
  localparam int unsigned SWD_REPLY_DLY = 16;
  localparam int unsigned SWD_REPLY_LOW = 128;
  localparam int unsigned SWD_ACK_LOW = 16;
  localparam int unsigned SWD_CNT_W = 10;
  localparam logic SWD_HS_RESET = 1'b0;
  typedef enum logic [2:0] {
    SWD_IDLE, SWD_LOW, SWD_SYNC_WAIT, SWD_REPLY_DELAY, SWD_REPLY_DRIVE,
    SWD_REPLY_SPEEDUP
  } swd_link_t;
  typedef enum logic [2:0] {
    SWD_DBG, SWD_STEP_RUN, SWD_STEP_LP, SWD_USER
  } swd_step_t;
endpackage

// ---- swd_rst_sync.sv ----
// Purpose: release of the asynchronous reset through two flops
// Assumes: rst_b active low
// Notes: assertion is immediate, release is synchronous
`timescale 1ns/10ps
module swd_rst_sync (
  input wire logic clk,
  input wire logic rst_b,
  output logic rst_sync_b
);
  logic stage;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      stage <= 1'b1;
      rst_sync_b <= stage;
    end
  end
endmodule

// ---- swd_pin_sync.sv ----
// Purpose: two-flop synchroniser of the background pin with fall/rise
// Assumes: pin idles high
// Notes: edges come from the second and third stages only
`timescale 1ns/10ps
module swd_pin_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic pin_level,
  output logic pin_fall,
  output logic pin_rise
);
  logic meta;
  logic last;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b1;
      pin_level <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= pin_in;
      pin_level <= meta;
      last <= pin_level;
    end
  end
  assign pin_fall = last & ~pin_level;
  assign pin_rise = ~last & pin_level;
endmodule

// ---- swd_debug_port.sv ----
// Purpose: serial time-out, sync reply and single-step control
// Assumes: command decode outside; pulses below are one cycle
// Notes: pin output enable is low while this end drives the pin
`timescale 1ns/10ps
module swd_debug_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic background_pin_in,
  output logic background_pin_out,
  output logic background_pin_oe_b,
  input wire logic cmd_partial,
  input wire logic cmd_done,
  input wire logic read_pending,
  input wire logic handshake_on_cmd,
  input wire logic handshake_off_cmd,
  input wire logic single_step_cmd,
  input wire logic halt_to_debug_cmd,
  input wire logic ack_request,
  input wire logic irq_pending,
  input wire logic instr_done,
  input wire logic instr_low_power,
  input wire logic low_power_exit,
  input wire logic system_stop,
  output logic bit_valid,
  output logic bit_value,
  output logic soft_reset,
  output logic sync_seen,
  output logic handshake_en,
  output logic cmd_allowed,
  output logic halt_allowed,
  output logic run_user,
  output logic stack_irq,
  output logic debug_active,
  output logic step_in_low_power
);
  import swd_pkg::*;

  localparam logic [SWD_CNT_W-1:0] SYNC_CNT = SWD_CNT_W'(SWD_SYNC_MIN);
  localparam logic [SWD_CNT_W-1:0] TO_CNT = SWD_CNT_W'(SWD_TIMEOUT);
  localparam logic [SWD_CNT_W-1:0] DLY_CNT = SWD_CNT_W'(SWD_REPLY_DLY);
  localparam logic [SWD_CNT_W-1:0] LOW_CNT = SWD_CNT_W'(SWD_REPLY_LOW);
  localparam logic [SWD_CNT_W-1:0] ACK_CNT = SWD_CNT_W'(SWD_ACK_LOW);
  localparam logic [SWD_CNT_W-1:0] HALF_CNT = SWD_CNT_W'(SWD_SYNC_MIN / 2);

  logic rst_sync_b;
  logic pin_level;
  logic pin_fall;
  logic pin_rise;
  swd_link_t link;
  swd_step_t step;
  logic [SWD_CNT_W-1:0] low_cnt;
  logic [SWD_CNT_W-1:0] edge_cnt;
  logic [SWD_CNT_W-1:0] drv_cnt;
  logic to_armed;
  logic hs_wait;
  logic timeout;
  logic ack_busy;
  logic ack_fire;
  logic suppress_ack;
  logic irq_step;
  logic host_fall;
  logic [SWD_CNT_W-1:0] ack_cnt;

  function automatic logic [SWD_CNT_W-1:0] sat_inc(
    input logic [SWD_CNT_W-1:0] v
  );
    sat_inc = (&v) ? v : v + SWD_CNT_W'(1);
  endfunction

  swd_rst_sync u_rst (
    .clk(clk),
    .rst_b(rst_b),
    .rst_sync_b(rst_sync_b)
  );

  swd_pin_sync u_pin (
    .clk(clk),
    .rst_b(rst_sync_b),
    .pin_in(background_pin_in),
    .pin_level(pin_level),
    .pin_fall(pin_fall),
    .pin_rise(pin_rise)
  );

  // own handshake pulse would otherwise read back as a host bit
  assign host_fall = pin_fall && (ack_cnt == '0);

  // host pulses are only watched while this end does not drive
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      link <= SWD_IDLE;
      low_cnt <= '0;
      drv_cnt <= '0;
    end else begin
      unique case (link)
        SWD_IDLE: begin
          low_cnt <= '0;
          if (host_fall) begin
            link <= SWD_LOW;
          end
        end
        SWD_LOW: begin
          low_cnt <= sat_inc(low_cnt);
          if (pin_level) begin
            link <= SWD_IDLE;
          end else if (low_cnt >= SYNC_CNT) begin
            link <= SWD_SYNC_WAIT;
          end
        end
        SWD_SYNC_WAIT: begin
          drv_cnt <= '0;
          if (pin_level) begin
            link <= SWD_REPLY_DELAY;
          end
        end
        SWD_REPLY_DELAY: begin
          drv_cnt <= drv_cnt + SWD_CNT_W'(1);
          if (drv_cnt == DLY_CNT - SWD_CNT_W'(1)) begin
            drv_cnt <= '0;
            link <= SWD_REPLY_DRIVE;
          end
        end
        SWD_REPLY_DRIVE: begin
          drv_cnt <= drv_cnt + SWD_CNT_W'(1);
          if (drv_cnt == LOW_CNT - SWD_CNT_W'(1)) begin
            link <= SWD_REPLY_SPEEDUP;
          end
        end
        SWD_REPLY_SPEEDUP: begin
          link <= SWD_IDLE;
        end
        default: link <= SWD_IDLE;
      endcase
    end
  end

  // a pulse under half the sync length reads as a one
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bit_valid <= 1'b0;
      bit_value <= 1'b0;
      sync_seen <= 1'b0;
    end else begin
      bit_valid <= (link == SWD_LOW) && pin_level;
      bit_value <= low_cnt < HALF_CNT;
      sync_seen <= (link == SWD_LOW) && !pin_level &&
        (low_cnt >= SYNC_CNT);
    end
  end

  // inter-edge time-out; held off while a handshaked read waits
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      edge_cnt <= '0;
      to_armed <= 1'b0;
      hs_wait <= 1'b0;
    end else begin
      if (host_fall || ack_fire || timeout || sync_seen || !to_armed) begin
        edge_cnt <= '0;
      end else if (to_armed && !hs_wait) begin
        edge_cnt <= sat_inc(edge_cnt);
      end
      to_armed <= (cmd_partial || read_pending) && !timeout &&
        !sync_seen;
      if (ack_fire || timeout || sync_seen || !read_pending) begin
        hs_wait <= 1'b0;
      end else if (cmd_done && handshake_en) begin
        hs_wait <= 1'b1;
      end
    end
  end
  assign timeout = to_armed && !hs_wait && (edge_cnt >= TO_CNT);
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= timeout || sync_seen;
    end
  end

  // handshake enable register
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      handshake_en <= SWD_HS_RESET;
    end else if (system_stop) begin
      handshake_en <= 1'b0;
    end else if (handshake_on_cmd) begin
      handshake_en <= 1'b1;
    end else if (handshake_off_cmd) begin
      handshake_en <= 1'b0;
    end
  end

  // single-step sequencing
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      step <= SWD_DBG;
      suppress_ack <= 1'b0;
      stack_irq <= 1'b0;
      irq_step <= 1'b0;
    end else begin
      stack_irq <= 1'b0;
      unique case (step)
        SWD_DBG: begin
          if (single_step_cmd && cmd_allowed) begin
            suppress_ack <= 1'b0;
            step <= SWD_STEP_RUN;
            stack_irq <= irq_pending;
            irq_step <= irq_pending;
          end
        end
        SWD_STEP_RUN: begin
          if (instr_done && instr_low_power && !irq_step) begin
            suppress_ack <= 1'b1;
            step <= SWD_STEP_LP;
          end else if (instr_done) begin
            step <= SWD_DBG;
          end
        end
        SWD_STEP_LP: begin
          if (low_power_exit) begin
            step <= SWD_DBG;
          end
        end
        default: step <= SWD_DBG;
      endcase
    end
  end
  assign debug_active = step == SWD_DBG;
  // stacking only: no user instruction runs on an interrupt step
  assign run_user = step == SWD_STEP_RUN && !irq_step;
  assign step_in_low_power = step == SWD_STEP_LP;
  assign cmd_allowed = !system_stop;
  assign halt_allowed = !system_stop && !step_in_low_power;

  // handshake pulse; the stepped low-power return gets none
  assign ack_fire = ack_request && handshake_en && !ack_busy &&
    !(suppress_ack && step == SWD_STEP_LP && low_power_exit);
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ack_busy <= 1'b0;
    end else if (sync_seen) begin
      ack_busy <= 1'b0;
    end else if (ack_fire) begin
      ack_busy <= 1'b1;
    end else if (ack_busy && ack_cnt == SWD_CNT_W'(1)) begin
      ack_busy <= 1'b0;
    end
  end
  // one extra count for the high speedup cycle; sync aborts the pulse
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ack_cnt <= '0;
    end else if (sync_seen) begin
      ack_cnt <= '0;
    end else if (ack_fire) begin
      ack_cnt <= ACK_CNT + SWD_CNT_W'(1);
    end else if (ack_cnt != '0) begin
      ack_cnt <= ack_cnt - SWD_CNT_W'(1);
    end
  end

  always_comb begin
    background_pin_out = 1'b1;
    background_pin_oe_b = 1'b1;
    if (link == SWD_REPLY_DRIVE || ack_cnt > SWD_CNT_W'(1)) begin
      background_pin_out = 1'b0;
      background_pin_oe_b = 1'b0;
    end else if (link == SWD_REPLY_SPEEDUP || ack_cnt == SWD_CNT_W'(1)) begin
      background_pin_oe_b = 1'b0;
    end
  end

  // reply delay: sixteen quiet cycles, then the low drive
  sequence s_reply_quiet;
    background_pin_oe_b [*8];
  endsequence

  property p_sync_reply;
    @(posedge clk) disable iff (!rst_sync_b)
      (link == SWD_SYNC_WAIT && pin_level) |=>
        s_reply_quiet ##1 s_reply_quiet ##1
        (!background_pin_oe_b && !background_pin_out);
  endproperty
  a_sync_reply: assert property (p_sync_reply)
    else $error("sync reply not driven after 16 cycles");

  property p_timeout;
    @(posedge clk) disable iff (!rst_sync_b)
      timeout |=> soft_reset;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("time-out did not soft reset");

  property p_hs_hold;
    @(posedge clk) disable iff (!rst_sync_b)
      (hs_wait && !host_fall && !ack_fire && !sync_seen) |=>
        (edge_cnt == $past(edge_cnt));
  endproperty
  a_hs_hold: assert property (p_hs_hold)
    else $error("time-out during handshaked read wait");

  property p_stop_hs;
    @(posedge clk) disable iff (!rst_sync_b)
      system_stop |=> !handshake_en;
  endproperty
  a_stop_hs: assert property (p_stop_hs)
    else $error("handshake kept in system stop");

  property p_stop_cmd;
    @(posedge clk) disable iff (!rst_sync_b)
      system_stop |-> !cmd_allowed && !halt_allowed;
  endproperty
  a_stop_cmd: assert property (p_stop_cmd)
    else $error("command allowed in system stop");

  property p_lp_exit;
    @(posedge clk) disable iff (!rst_sync_b)
      (step_in_low_power && low_power_exit) |=> debug_active;
  endproperty
  a_lp_exit: assert property (p_lp_exit)
    else $error("no return to debug after low power");

  property p_sync_seen;
    @(posedge clk) disable iff (!rst_sync_b)
      sync_seen |=> soft_reset;
  endproperty
  a_sync_seen: assert property (p_sync_seen)
    else $error("sync did not discard transfer");

  property p_lp_halt;
    @(posedge clk) disable iff (!rst_sync_b)
      step_in_low_power |-> !halt_allowed;
  endproperty
  a_lp_halt: assert property (p_lp_halt)
    else $error("halt allowed in stepped low power");

  sequence s_ack_low;
    (!background_pin_oe_b && !background_pin_out) [*8];
  endsequence

  property p_ack_pulse;
    @(posedge clk) disable iff (!rst_sync_b || sync_seen)
      ack_fire |=> s_ack_low ##1 s_ack_low ##1
        (!background_pin_oe_b && background_pin_out);
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("handshake pulse shape wrong");

  property p_irq_step;
    @(posedge clk) disable iff (!rst_sync_b)
      stack_irq |-> !run_user;
  endproperty
  a_irq_step: assert property (p_irq_step)
    else $error("user code ran on an interrupt step");
endmodule

// ---- swd_host_model.sv ----
// Purpose: external debug host pulling the background pin low
// Assumes: pin has a pull-up; host only ever pulls low
// Notes: releasing the pin hands it back to the pull-up
`timescale 1ns/10ps
module swd_host_model (
  input wire logic clk,
  output logic drive_low
);
  initial drive_low = 1'b0;
  // one low pulse of n cycles; short ones are bits, long ones sync
  task automatic pulse(input int n);
    @(negedge clk);
    drive_low = 1'b1;
    repeat (n) @(negedge clk);
    drive_low = 1'b0;
  endtask
endmodule

// ---- tb_top.sv ----
// Purpose: self-checking bench of the debug port logic
// Assumes: clk is also the serial clock
// Notes: inputs change on the falling edge of clk
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pin, out, oe_b, host_low;
  logic cp = 0, cd = 0, rp = 0, hon = 0, hoff = 0, st = 0, halt = 0;
  logic ack = 0, irq = 0, idone = 0, ilp = 0, lpx = 0, sstop = 0;
  logic bv, bval, sr, ss, hen, ca, ha, ru, sk, da, slp;
  logic got_bit, got_one, got_soft, got_sync, got_stack, got_drv;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int k;
  always #10 clk = ~clk;
  // open drain: either party may pull low, pull-up otherwise
  assign pin = ~host_low & (oe_b | out);
  swd_host_model host_u (.clk(clk), .drive_low(host_low));
  swd_debug_port dut_u (.clk(clk), .rst_b(rst_b),
    .background_pin_in(pin), .background_pin_out(out),
    .background_pin_oe_b(oe_b), .cmd_partial(cp), .cmd_done(cd),
    .read_pending(rp), .handshake_on_cmd(hon),
    .handshake_off_cmd(hoff), .single_step_cmd(st),
    .halt_to_debug_cmd(halt), .ack_request(ack), .irq_pending(irq),
    .instr_done(idone), .instr_low_power(ilp),
    .low_power_exit(lpx), .system_stop(sstop), .bit_valid(bv),
    .bit_value(bval), .soft_reset(sr), .sync_seen(ss),
    .handshake_en(hen), .cmd_allowed(ca), .halt_allowed(ha),
    .run_user(ru), .stack_irq(sk), .debug_active(da),
    .step_in_low_power(slp));
  // sticky copies so that one-cycle pulses are never missed
  always @(posedge clk) begin
    if (bv) begin
      got_bit <= 1'b1;
      got_one <= bval;
    end
    if (sr) got_soft <= 1'b1;
    if (ss) got_sync <= 1'b1;
    if (sk) got_stack <= 1'b1;
    if (!oe_b) got_drv <= 1'b1;
  end
  task automatic clr();
    got_bit = 0;
    got_one = 0;
    got_soft = 0;
    got_sync = 0;
    got_stack = 0;
    got_drv = 0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ceiling well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  // also used in mid-run: handshake must fall back to off
  task automatic t_reset();
    rst_b = 1'b0;
    wait_n(20);
    rst_b = 1'b1;
    wait_n(3);
    chk(hen, 1'b0);
    chk(oe_b, 1'b1);
    chk(da, 1'b1);
    $display("done reset");
  endtask
  // held low past the time-out too: the wait for the rise never times out
  task automatic t_sync();
    clr();
    host_u.pulse(600);
    chk(got_sync, 1'b1);
    chk(got_soft, 1'b1);
    for (k = 0; k < 40 && oe_b; k++) @(negedge clk);
    chk(k > 14 && k < 22, 1'b1);
    for (k = 0; k < 300 && !oe_b && !pin; k++) @(negedge clk);
    chk(k, 128);
    $display("done sync");
  endtask
  task automatic t_timeout();
    cp = 1'b1;
    clr();
    host_u.pulse(10);
    wait_n(4);
    chk(got_bit, 1'b1);
    chk(got_one, 1'b1);
    for (k = 14; k < 600 && !got_soft; k++) @(negedge clk);
    chk(k > 505 && k < 520, 1'b1);
    cp = 1'b0;
    clr();
    host_u.pulse(100);
    wait_n(4);
    chk(got_bit, 1'b1);
    chk(got_one, 1'b0);
    $display("done timeout");
  endtask
  task automatic t_read(input logic hs);
    rp = 1'b1;
    clr();
    host_u.pulse(10);
    cd = 1'b1;
    @(negedge clk);
    cd = 1'b0;
    if (hs) begin
      wait_n(700);
      chk(got_soft, 1'b0);
      ack = 1'b1;
      @(negedge clk);
      ack = 1'b0;
      for (k = 0; k < 600 && !got_soft; k++) @(negedge clk);
      chk(k > 505 && k < 530, 1'b1);
      chk(got_drv, 1'b1);
    end else begin
      for (k = 11; k < 600 && !got_soft; k++) @(negedge clk);
      chk(k > 505 && k < 520, 1'b1);
    end
    rp = 1'b0;
    $display("done read");
  endtask
  task automatic hs_on();
    hon = 1'b1;
    @(negedge clk);
    hon = 1'b0;
    wait_n(2);
  endtask
  // host steps ordinary opcodes only, never the soft breakpoint
  task automatic step();
    st = 1'b1;
    @(negedge clk);
    st = 1'b0;
  endtask
  task automatic done1();
    idone = 1'b1;
    @(negedge clk);
    idone = 1'b0;
  endtask
  task automatic t_step();
    step();
    wait_n(2);
    chk(ru, 1'b1);
    done1();
    wait_n(2);
    chk(da, 1'b1);
    chk(ru, 1'b0);
    irq = 1'b1;
    clr();
    step();
    wait_n(3);
    chk(got_stack, 1'b1);
    chk(ru, 1'b0);
    irq = 1'b0;
    done1();
    wait_n(2);
    chk(da, 1'b1);
    step();
    ilp = 1'b1;
    done1();
    wait_n(2);
    chk(slp, 1'b1);
    chk(ca, 1'b1);
    chk(ha, 1'b0);
    clr();
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    wait_n(25);
    chk(got_drv, 1'b1);
    chk(got_bit, 1'b0);
    clr();
    lpx = 1'b1;
    ack = 1'b1;
    @(negedge clk);
    lpx = 1'b0;
    ack = 1'b0;
    ilp = 1'b0;
    wait_n(30);
    chk(da, 1'b1);
    chk(got_drv, 1'b0);
    $display("done step");
  endtask
  // stop refuses commands, so it runs last
  task automatic t_stop();
    hs_on();
    sstop = 1'b1;
    wait_n(2);
    chk(hen, 1'b0);
    chk(ca, 1'b0);
    chk(ha, 1'b0);
    step();
    wait_n(2);
    chk(ru, 1'b0);
    sstop = 1'b0;
    wait_n(2);
    chk(hen, 1'b0);
    hs_on();
    chk(hen, 1'b1);
    hoff = 1'b1;
    @(negedge clk);
    hoff = 1'b0;
    wait_n(2);
    chk(hen, 1'b0);
    $display("done stop");
  endtask
  initial begin
    clr();
    t_reset();
    t_sync();
    t_timeout();
    t_read(1'b0);
    hs_on();
    chk(hen, 1'b1);
    t_read(1'b1);
    t_step();
    t_reset();
    t_stop();
    give_verdict();
  end
endmodule
